/* File: mirq_pkg.sv */
// Constants, register map and carrier types for the interrupt controller
// What this block does
// - Eleven request sources: edge pin, timer overflow, port change, eight peripheral flags.
// - Global enable set lets enabled requests interrupt; cleared, nothing interrupts.
// - Reset clears global enable and zeroes control, peripheral flag and enable registers.
// - Taking an interrupt clears global enable, pushes return address, loads vector 0004h.
// - Return-from-interrupt sets global enable again.
// - Each flag sets on its event regardless of any enable.
// - Request blocked by a global-enable clear stays pending until re-enabled.
// - External event latency to the vector command is 10 to 13 clocks, two and a half to three and a quarter instruction cycles.
// - Edge flag may set any phase; requests are sampled once per cycle at Q1.
// - Edge pin flag sets on rising or falling edge per polarity select.
// - Edge pin wakes from sleep only if its enable was set before sleep.
// - Analog-selected pins read zero and raise no request.
// - Timer count rolling FFh to 00h sets the timer overflow flag.
// - Change on a port pin enabled in the change mask sets port change flag.
// - A pin change during a port access may be missed.
// - Core flags and enables in control register; peripheral flags and enables paired.
// - Wake continues at next instruction, then vectors if global enable set.
// - Interrupt wake sets watchdog expiry flag and clears powerdown flag.
// - Edge pin, port change and qualified peripherals may wake from sleep; the code also wakes on a timer overflow with its enable set.
package mirq_pkg;

    // Register indices; byte address is four times the index
    localparam logic [9:0] IDX_STATUS      = 10'h003;
    localparam logic [9:0] IDX_CORE_CTL    = 10'h00b;
    localparam logic [9:0] IDX_PERIPH_FLAG = 10'h00c;
    localparam logic [9:0] IDX_OPTION      = 10'h081;
    localparam logic [9:0] IDX_PERIPH_EN   = 10'h08c;
    localparam logic [9:0] IDX_ANALOG_SEL  = 10'h091;
    localparam logic [9:0] IDX_PIN_CHANGE  = 10'h096;

    // Field positions in core_interrupt_control; enables 5:3 pair with flags 2:0
    localparam int BIT_GLB_EN  = 7;
    localparam int BIT_GRP_EN  = 6;
    localparam int BIT_OVF_EN  = 5;
    localparam int BIT_EDGE_EN = 4;
    localparam int BIT_CHG_EN  = 3;
    localparam int BIT_OVF_FL  = 2;
    localparam int BIT_EDGE_FL = 1;
    localparam int BIT_CHG_FL  = 0;

    // Other field positions
    localparam int BIT_EDGE_POL = 6;   // In option register
    localparam int BIT_WDT_EXP  = 4;   // In status register
    localparam int BIT_PWRDN    = 3;   // In status register
    localparam int EDGE_PIN     = 2;   // Port A pin carrying the edge input

    // Reset values
    localparam logic [7:0] RST_CORE_CTL    = 8'h00;
    localparam logic [7:0] RST_PERIPH_FLAG = 8'h00;
    localparam logic [7:0] RST_PERIPH_EN   = 8'h00;
    localparam logic [5:0] RST_PIN_CHANGE  = 6'h00;
    localparam logic [7:0] RST_OPTION      = 8'hff;
    localparam logic [7:0] RST_ANALOG_SEL  = 8'hff;
    localparam logic [1:0] RST_STATUS      = 2'h3;

    // Vector and timing
    localparam logic [12:0] IRQ_VECTOR     = 13'h0004;
    localparam int          Q_PER_TCY      = 4;
    localparam logic [1:0]  Q1             = 2'h0;
    localparam logic [1:0]  TAKE_Q1_COUNT  = 2'h2;  // Q1 samples before vectoring
    localparam logic [7:0]  TIMER_MAX      = 8'hff;
    localparam logic [7:0]  TIMER_ZERO     = 8'h00;

    // AHB constants
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] HSIZE_WORD    = 3'h2;

    // Inputs from the core sequencer
    typedef struct packed {
        logic return_from_irq;   // One-cycle pulse on executing return
        logic sleeping;          // Level while the core sleeps
        logic port_a_access;     // Pulse while a port A read or write runs
    } mirq_core_in_t;

    // Commands to the core sequencer
    typedef struct packed {
        logic        take;       // Pulse: push return address, load vector
        logic        wake;       // Pulse: leave sleep
        logic        pending;    // Level: enabled request with global enable
        logic [12:0] vector;     // Vector address
    } mirq_core_out_t;

endpackage

/* File: mirq_ctrl.sv */
// Interrupt controller top: flags, enables, Q1 sampling, vectoring, wake and AHB-Lite slave
//
// The implementer's own choice: the AHB-Lite interface to the registers.
`timescale 1ns/10ps
module mirq_ctrl #(
    parameter int ADDR_W = 12,
    parameter int PORT_W = 6
) (
    // Clock, reset, enable
    input  wire logic                     clk_in,
    input  wire logic                     nrst_in,
    input  wire logic                     ce_in,
    // AHB-Lite slave
    input  wire logic                     hsel_in,
    input  wire logic [ADDR_W-1:0]        haddr_in,
    input  wire logic [1:0]               htrans_in,
    input  wire logic                     hwrite_in,
    input  wire logic [2:0]               hsize_in,
    input  wire logic [31:0]              hwdata_in,
    input  wire logic                     hready_in,
    output logic                          hreadyout_out,
    output logic                          hresp_out,
    output logic [31:0]                   hrdata_out,
    // Event sources
    input  wire logic [PORT_W-1:0]        port_a_pins_in,
    input  wire logic [7:0]               timer_a_count_in,
    input  wire logic [7:0]               periph_event_in,
    input  wire logic [7:0]               periph_wake_qual_in,
    // Core sequencer
    input  wire mirq_pkg::mirq_core_in_t  core_in,
    output mirq_pkg::mirq_core_out_t      core_out,
    output logic [PORT_W-1:0]             port_a_read_out
);
    import mirq_pkg::*;

    // Elaboration check: pin logic is six wide and the map needs twelve address bits
    if (PORT_W != 6 || ADDR_W < 12 || ADDR_W > 32) begin : g_bad_param
        $error("mirq_ctrl: unsupported PORT_W or ADDR_W");
    end

    // Register storage
    logic [7:0]        core_interrupt_control;
    logic [7:0]        peripheral_interrupt_flags;
    logic [7:0]        peripheral_interrupt_enables;
    logic [5:0]        pin_change_enable_mask;
    logic [7:0]        option_ctl;
    logic [7:0]        analog_select;
    logic [1:0]        wake_status;

    // Bus pipeline
    logic              ap_write;
    logic              ap_read;
    logic [9:0]        ap_idx;
    logic              ap_ok;
    logic              rd_wait;

    // Event detection
    logic [5:0]        port_prev;
    logic [7:0]        timer_prev;
    logic [1:0]        q_phase;
    logic [1:0]        q1_count;
    logic              edge_en_sleep;
    logic              sleep_prev;
    logic              wake_sent;

    // Combinational helpers
    logic [5:0]        port_digital;
    logic              edge_hit;
    logic              change_hit;
    logic              ovf_hit;
    logic              core_req;
    logic              periph_req;
    logic              any_req;
    logic              wake_req;
    logic              take_now;
    logic              addr_take;
    logic              wr_core;
    logic              wr_pflag;
    logic              wr_pen;
    logic [7:0]        wdata;
    logic [7:0]        next_core_ctl;
    logic [7:0]        next_pflags;
    logic [7:0]        rd_value;

    // Register read multiplexer; unmapped indices read zero
    function automatic logic [7:0] reg_read(input logic [9:0] idx);
        case (idx)
            IDX_STATUS:      reg_read = {3'h0, wake_status, 3'h0};
            IDX_CORE_CTL:    reg_read = core_interrupt_control;
            IDX_PERIPH_FLAG: reg_read = peripheral_interrupt_flags;
            IDX_OPTION:      reg_read = option_ctl;
            IDX_PERIPH_EN:   reg_read = peripheral_interrupt_enables;
            IDX_ANALOG_SEL:  reg_read = analog_select;
            IDX_PIN_CHANGE:  reg_read = {2'h0, pin_change_enable_mask};
            default:         reg_read = 8'h00;
        endcase
    endfunction

    // Address phase decode; only aligned word transfers reach a register
    assign addr_take = ce_in && hsel_in && hready_in && (htrans_in == HTRANS_NONSEQ);
    assign wdata     = hwdata_in[7:0];
    assign wr_core   = ap_write && ap_ok && (ap_idx == IDX_CORE_CTL);
    assign wr_pflag  = ap_write && ap_ok && (ap_idx == IDX_PERIPH_FLAG);
    assign wr_pen    = ap_write && ap_ok && (ap_idx == IDX_PERIPH_EN);
    assign rd_value  = reg_read(ap_idx);

    // Address phase capture
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            ap_write <= 1'b0;
            ap_read  <= 1'b0;
            ap_idx   <= 10'h000;
            ap_ok    <= 1'b0;
        end else if (ce_in) begin
            if (hready_in && hreadyout_out) begin
                ap_write <= addr_take && hwrite_in;
                ap_read  <= addr_take && !hwrite_in;
                ap_idx   <= haddr_in[11:2];
                ap_ok    <= (haddr_in[1:0] == 2'h0) && (hsize_in == HSIZE_WORD)
                            && ((haddr_in >> 12) == '0);
            end else if (rd_wait) begin
                ap_read <= 1'b0;
            end
        end
    end

    // Reads take one wait state so the data reflects any write just completed
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            hreadyout_out <= 1'b1;
            hresp_out     <= 1'b0;
            hrdata_out    <= 32'h0000_0000;
            rd_wait       <= 1'b0;
        end else if (ce_in) begin
            hresp_out <= 1'b0;
            if (hready_in && hreadyout_out && addr_take && !hwrite_in) begin
                hreadyout_out <= 1'b0;
                rd_wait       <= 1'b1;
            end else if (rd_wait) begin
                hreadyout_out <= 1'b1;
                rd_wait       <= 1'b0;
                hrdata_out    <= {24'h00_0000, (ap_read && ap_ok) ? rd_value : 8'h00};
            end
        end
    end

    // Pin conditioning: analog pins read zero and never request
    assign port_digital = port_a_pins_in & ~analog_select[5:0];
    assign edge_hit     = option_ctl[BIT_EDGE_POL]
                          ? (port_digital[EDGE_PIN] && !port_prev[EDGE_PIN])
                          : (!port_digital[EDGE_PIN] && port_prev[EDGE_PIN]);
    assign change_hit   = |((port_digital ^ port_prev) & pin_change_enable_mask)
                          && !core_in.port_a_access;
    assign ovf_hit      = (timer_prev == TIMER_MAX) && (timer_a_count_in == TIMER_ZERO);

    // Pin and timer history
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            port_prev       <= 6'h00;
            timer_prev      <= 8'h00;
            port_a_read_out <= '0;
        end else if (ce_in) begin
            port_prev       <= port_digital;
            timer_prev      <= timer_a_count_in;
            port_a_read_out <= port_digital;
        end
    end

    // Request combination from flags and enables
    // Enables 5:3 sit in the same order as flags 2:0, so one AND pairs them
    assign core_req   = |(core_interrupt_control[BIT_OVF_EN -: 3]
                          & core_interrupt_control[BIT_OVF_FL -: 3]);
    assign periph_req = core_interrupt_control[BIT_GRP_EN]
                        && |(peripheral_interrupt_flags & peripheral_interrupt_enables);
    assign any_req    = core_req || periph_req;
    // Vectoring only at a Q1 boundary, after the required samples, while awake
    assign take_now   = (q_phase == Q1) && !core_in.sleeping
                        && core_interrupt_control[BIT_GLB_EN] && any_req
                        && (q1_count == TAKE_Q1_COUNT);

    // Wake needs the edge enable as it stood on sleep entry
    assign wake_req = (edge_en_sleep && core_interrupt_control[BIT_EDGE_FL])
                      || (core_interrupt_control[BIT_CHG_EN]
                          && core_interrupt_control[BIT_CHG_FL])
                      || (core_interrupt_control[BIT_OVF_EN]
                          && core_interrupt_control[BIT_OVF_FL])
                      || (core_interrupt_control[BIT_GRP_EN]
                          && |(peripheral_interrupt_flags & peripheral_interrupt_enables
                               & periph_wake_qual_in));

    // Next value of the core control register; hardware set beats software clear
    always_comb begin
        next_core_ctl = core_interrupt_control;
        if (wr_core) begin
            next_core_ctl = wdata;
        end
        if (take_now) begin
            next_core_ctl[BIT_GLB_EN] = 1'b0;
        end else if (core_in.return_from_irq) begin
            next_core_ctl[BIT_GLB_EN] = 1'b1;
        end
        if (ovf_hit) begin
            next_core_ctl[BIT_OVF_FL] = 1'b1;
        end
        if (edge_hit) begin
            next_core_ctl[BIT_EDGE_FL] = 1'b1;
        end
        if (change_hit) begin
            next_core_ctl[BIT_CHG_FL] = 1'b1;
        end
    end

    // Peripheral flags: events set regardless of enables, set wins over write
    always_comb begin
        next_pflags = wr_pflag ? wdata : peripheral_interrupt_flags;
        next_pflags = next_pflags | periph_event_in;
    end

    // Interrupt control and flag registers
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            core_interrupt_control     <= RST_CORE_CTL;
            peripheral_interrupt_flags <= RST_PERIPH_FLAG;
        end else if (ce_in) begin
            core_interrupt_control     <= next_core_ctl;
            peripheral_interrupt_flags <= next_pflags;
        end
    end

    // Plain software-owned configuration registers
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            peripheral_interrupt_enables <= RST_PERIPH_EN;
            pin_change_enable_mask       <= RST_PIN_CHANGE;
            option_ctl                   <= RST_OPTION;
            analog_select                <= RST_ANALOG_SEL;
        end else if (ce_in && ap_write && ap_ok) begin
            if (wr_pen) begin
                peripheral_interrupt_enables <= wdata;
            end
            if (ap_idx == IDX_PIN_CHANGE) begin
                pin_change_enable_mask <= wdata[5:0];
            end
            if (ap_idx == IDX_OPTION) begin
                option_ctl <= wdata;
            end
            if (ap_idx == IDX_ANALOG_SEL) begin
                analog_select <= wdata;
            end
        end
    end

    // Q phase counter; free-running, a take does not restart the instruction cycle
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            q_phase <= Q1;
        end else if (ce_in) begin
            q_phase <= 2'((int'(q_phase) + 1) % Q_PER_TCY);
        end
    end

    // Q1 sampling: a request dropped by a global-enable clear restarts its count
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            q1_count <= 2'h0;
        end else if (ce_in && q_phase == Q1) begin
            if (!core_interrupt_control[BIT_GLB_EN] || !any_req || core_in.sleeping) begin
                q1_count <= 2'h0;
            end else if (take_now) begin
                q1_count <= 2'h0;
            end else begin
                q1_count <= q1_count + 2'h1;
            end
        end
    end

    // Sleep tracking and wake status bits
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            sleep_prev    <= 1'b0;
            edge_en_sleep <= 1'b0;
            wake_sent     <= 1'b0;
            wake_status   <= RST_STATUS;
        end else if (ce_in) begin
            sleep_prev <= core_in.sleeping;
            if (core_in.sleeping && !sleep_prev) begin
                edge_en_sleep <= core_interrupt_control[BIT_EDGE_EN];
            end
            if (!core_in.sleeping) begin
                wake_sent <= 1'b0;
            end else if (wake_req && !wake_sent) begin
                wake_sent   <= 1'b1;
                wake_status <= 2'b10;
            end
        end
    end

    // Commands to the core, all registered
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            core_out <= '{take: 1'b0, wake: 1'b0, pending: 1'b0, vector: IRQ_VECTOR};
        end else if (ce_in) begin
            core_out.take    <= take_now;
            core_out.wake    <= core_in.sleeping && wake_req && !wake_sent;
            core_out.pending <= core_interrupt_control[BIT_GLB_EN] && any_req;
            core_out.vector  <= IRQ_VECTOR;
        end
    end

endmodule

/* File: mirq_checker.sv */
// Concurrent checks on the interrupt controller's bus and core ports
`timescale 1ns/10ps
module mirq_checker (
    // Clock, reset, enable
    input wire logic                     clk_in,
    input wire logic                     nrst_in,
    input wire logic                     ce_in,
    // Bus
    input wire logic                     hsel_in,
    input wire logic [1:0]               htrans_in,
    input wire logic                     hwrite_in,
    input wire logic                     hready_in,
    input wire logic                     hreadyout_out,
    input wire logic                     hresp_out,
    input wire logic [31:0]              hrdata_out,
    // Core link
    input wire mirq_pkg::mirq_core_in_t  core_in,
    input wire mirq_pkg::mirq_core_out_t core_out
);
    import mirq_pkg::*;
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!nrst_in);
    // Bus requests taken at this edge
    sequence rd_req;
        ce_in && hsel_in && hready_in && hreadyout_out && htrans_in == HTRANS_NONSEQ && !hwrite_in;
    endsequence
    sequence wr_req;
        ce_in && hsel_in && hready_in && hreadyout_out && htrans_in == HTRANS_NONSEQ && hwrite_in;
    endsequence
    // A read costs exactly one wait cycle
    sequence rd_done;
        !hreadyout_out ##1 hreadyout_out;
    endsequence
    chk_read_wait: assert property (rd_req |=> rd_done)
        else $error("read did not take exactly one wait cycle");
    chk_write_nowait: assert property (wr_req |=> hreadyout_out)
        else $error("write stalled the bus");
    chk_resp_okay: assert property (hresp_out == 1'h0)
        else $error("error response on the bus");
    chk_rdata_upper: assert property (hrdata_out[31:8] == 24'h0)
        else $error("read data upper bits not zero");
    chk_rdata_hold: assert property (wr_req |=> $stable(hrdata_out))
        else $error("read data moved during a write");
    chk_take_spacing: assert property (core_out.take |=> !core_out.take [*4])
        else $error("vector command repeated too soon");
    chk_take_pending: assert property (core_out.take |-> $past(core_out.pending))
        else $error("vector command without a pending request");
    chk_take_asleep: assert property (core_in.sleeping [*2] |=> !core_out.take)
        else $error("vector command while asleep");
    chk_wake_pulse: assert property (core_out.wake |=> !core_out.wake)
        else $error("wake longer than one cycle");
    chk_wake_asleep: assert property (core_out.wake |-> $past(core_in.sleeping))
        else $error("wake while not asleep");
    chk_vector_fixed: assert property (core_out.vector == IRQ_VECTOR)
        else $error("vector address wrong");
endmodule
bind mirq_ctrl mirq_checker u_chk (
    .clk_in(clk_in), .nrst_in(nrst_in), .ce_in(ce_in), .hsel_in(hsel_in),
    .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hready_in(hready_in),
    .hreadyout_out(hreadyout_out), .hresp_out(hresp_out), .hrdata_out(hrdata_out),
    .core_in(core_in), .core_out(core_out)
);

/* File: mirq_core_model.sv */
// Behavioural core sequencer: sleep level and return from service
`timescale 1ns/10ps
module mirq_core_model #(
    parameter int RET_LAG = 3
) (
    // Clock and reset
    input  wire logic                     clk_in,
    input  wire logic                     nrst_in,
    // Scenario controls
    input  wire logic                     sleep_req_in,
    input  wire logic                     svc_done_in,
    // Controller link
    input  wire mirq_pkg::mirq_core_out_t cmd_in,
    output mirq_pkg::mirq_core_in_t       core_out
);
    import mirq_pkg::*;
    logic       sleeping;
    logic       ret;
    logic [3:0] lag;
    // Port accesses are not modelled, so no change is ever dropped
    assign core_out = '{return_from_irq: ret, sleeping: sleeping, port_a_access: 1'h0};
    // Sleep holds until the wake pulse; execution then simply continues
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            sleeping <= 1'h0;
        end else if (cmd_in.wake) begin
            sleeping <= 1'h0;
        end else if (sleep_req_in) begin
            sleeping <= 1'h1;
        end
    end
    // Return only after software reports the serviced flags cleared
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            lag <= 4'h0;
            ret <= 1'h0;
        end else begin
            ret <= (lag == 4'h1);
            if (svc_done_in) begin
                lag <= 4'(RET_LAG);
            end else if (lag != 4'h0) begin
                lag <= lag - 4'h1;
            end
        end
    end
endmodule

/* File: testbench.sv */
// Self-checking bench: registers, flags, vectoring and wake
`timescale 1ns/10ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin error_cnt++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (e)); end end
module testbench;
    import mirq_pkg::*;
    // Stimulus and observed signals
    logic                 clk_in = 1'h0, nrst_in = 1'h0, hwrite = 1'h0, hrdy;
    logic                 sleep_req = 1'h0, svc_done = 1'h0;
    logic [1:0]           htrans = 2'h0;
    logic [11:0]          haddr = 12'h000;
    logic [31:0]          hwdata = 32'h0, hrdata, rd;
    logic [5:0]           pins = 6'h00, pin_rd;
    logic [7:0]           tcnt = 8'h00, pev = 8'h00, qual = 8'h00;
    mirq_core_in_t        creq;
    mirq_core_out_t       cout;
    int                   error_cnt = 0, n_checks = 0, k;
    always #4 clk_in = ~clk_in;
    mirq_ctrl DUT (
        .clk_in(clk_in), .nrst_in(nrst_in), .ce_in(1'h1), .hsel_in(1'h1),
        .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(HSIZE_WORD),
        .hwdata_in(hwdata), .hready_in(hrdy), .hreadyout_out(hrdy), .hresp_out(),
        .hrdata_out(hrdata), .port_a_pins_in(pins), .timer_a_count_in(tcnt),
        .periph_event_in(pev), .periph_wake_qual_in(qual), .core_in(creq),
        .core_out(cout), .port_a_read_out(pin_rd));
    mirq_core_model #(.RET_LAG(3)) u_core (
        .clk_in(clk_in), .nrst_in(nrst_in), .sleep_req_in(sleep_req),
        .svc_done_in(svc_done), .cmd_in(cout), .core_out(creq));
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_in);
    endtask
    // Ready is sampled at rising edges only; a hang ends the run
    task automatic wait_rdy();
        int n;
        for (n = 0; n < 40; n++) begin
            @(posedge clk_in);
            if (hrdy === 1'h1) break;
        end
        if (n == 40) begin
            error_cnt++;
            print_verdict();
        end
    endtask
    // One single word transfer: address phase, then data phase
    task automatic bus(input logic w, input logic [9:0] idx, input logic [7:0] wd);
        htrans <= HTRANS_NONSEQ;
        haddr <= {idx, 2'h0};
        hwrite <= w;
        wait_rdy();
        htrans <= 2'h0;
        hwdata <= {24'h0, wd};
        wait_rdy();
        rd = hrdata;
    endtask
    task automatic wr(input logic [9:0] idx, input logic [7:0] v);
        bus(1'h1, idx, v);
    endtask
    task automatic expect_reg(input logic [9:0] idx, input logic [7:0] e);
        bus(1'h0, idx, 8'h00);
        `CHK(rd, {24'h0, e})
    endtask
    // Edges until the vector command; 60 means none came
    task automatic wait_take(output int n);
        for (n = 0; n < 60; n++) begin
            @(posedge clk_in);
            if (cout.take === 1'h1) break;
        end
    endtask
    // Service routine done: the core returns a few cycles later
    task automatic svc();
        svc_done <= 1'h1;
        cyc(1);
        svc_done <= 1'h0;
        cyc(6);
    endtask
    initial begin
        cyc(3);
        nrst_in <= 1'h1;
        cyc(1);
        expect_reg(IDX_CORE_CTL, RST_CORE_CTL);
        expect_reg(IDX_PERIPH_FLAG, RST_PERIPH_FLAG);
        expect_reg(IDX_PERIPH_EN, RST_PERIPH_EN);
        expect_reg(IDX_PIN_CHANGE, {2'h0, RST_PIN_CHANGE});
        wr(IDX_STATUS, 8'h00);
        expect_reg(IDX_STATUS, {3'h0, RST_STATUS, 3'h0});
        wr(10'h004, 8'h5a);
        expect_reg(10'h004, 8'h00);
        // Timer wrap and peripheral events with every enable off
        tcnt <= TIMER_MAX;
        cyc(2);
        tcnt <= TIMER_ZERO;
        cyc(2);
        expect_reg(IDX_CORE_CTL, 8'h01 << BIT_OVF_FL);
        wr(IDX_CORE_CTL, 8'h00);
        expect_reg(IDX_CORE_CTL, 8'h00);
        for (k = 0; k < 8; k++) begin
            pev <= 8'h01 << k;
            cyc(1);
            pev <= 8'h00;
            expect_reg(IDX_PERIPH_FLAG, 8'h01 << k);
            wr(IDX_PERIPH_FLAG, 8'h00);
        end
        // Peripheral request waits for the group enable
        wr(IDX_PERIPH_EN, 8'h40);
        pev <= 8'h40;
        cyc(1);
        pev <= 8'h00;
        wr(IDX_CORE_CTL, 8'h80);
        wait_take(k);
        `CHK(k, 60)
        wr(IDX_CORE_CTL, 8'hc0);
        wait_take(k);
        `CHK({cout.take, cout.vector}, {1'h1, IRQ_VECTOR})
        expect_reg(IDX_CORE_CTL, 8'h40);
        wr(IDX_PERIPH_FLAG, 8'h00);
        svc();
        expect_reg(IDX_CORE_CTL, 8'hc0);
        wait_take(k);
        `CHK(k, 60)
        wr(IDX_PERIPH_EN, 8'h00);
        // Edge pin made digital: rising edge, latency, return
        wr(IDX_ANALOG_SEL, 8'h00);
        wr(IDX_CORE_CTL, 8'h90);
        pins <= 6'h04;
        wait_take(k);
        `CHK(k >= 8 && k <= 13, 1'h1)
        `CHK(pin_rd, 6'h04)
        expect_reg(IDX_CORE_CTL, 8'h12);
        wr(IDX_CORE_CTL, 8'h10);
        svc();
        expect_reg(IDX_CORE_CTL, 8'h90);
        // Falling polarity; the flag waits while global enable is off
        wr(IDX_CORE_CTL, 8'h10);
        wr(IDX_OPTION, 8'hbf);
        pins <= 6'h00;
        expect_reg(IDX_CORE_CTL, 8'h12);
        wait_take(k);
        `CHK(k, 60)
        wr(IDX_CORE_CTL, 8'h92);
        wait_take(k);
        `CHK(cout.take, 1'h1)
        wr(IDX_CORE_CTL, 8'h00);
        svc();
        // Analog pins read zero and raise nothing
        wr(IDX_ANALOG_SEL, 8'hff);
        wr(IDX_CORE_CTL, 8'h00);
        pins <= 6'h3f;
        cyc(2);
        `CHK(pin_rd, 6'h00)
        pins <= 6'h00;
        expect_reg(IDX_CORE_CTL, 8'h00);
        // Port change: unmasked pin ignored, masked pin flags
        wr(IDX_ANALOG_SEL, 8'h00);
        wr(IDX_PIN_CHANGE, 8'h01);
        pins <= 6'h02;
        expect_reg(IDX_CORE_CTL, 8'h00);
        pins <= 6'h03;
        expect_reg(IDX_CORE_CTL, 8'h01);
        // Sleep with the edge enable set, woken by a rising edge
        wr(IDX_CORE_CTL, 8'h10);
        wr(IDX_OPTION, 8'hff);
        sleep_req <= 1'h1;
        cyc(1);
        sleep_req <= 1'h0;
        cyc(2);
        `CHK(creq.sleeping, 1'h1)
        pins <= 6'h07;
        cyc(8);
        `CHK(creq.sleeping, 1'h0)
        expect_reg(IDX_STATUS, 8'h10);
        // Peripheral wake only from a source in a wake-capable mode
        wr(IDX_PERIPH_EN, 8'h01);
        wr(IDX_CORE_CTL, 8'h40);
        sleep_req <= 1'h1;
        pev <= 8'h01;
        cyc(1);
        sleep_req <= 1'h0;
        pev <= 8'h00;
        cyc(8);
        `CHK(creq.sleeping, 1'h1)
        qual <= 8'h01;
        cyc(8);
        `CHK(creq.sleeping, 1'h0)
        print_verdict();
    end
endmodule
